// File: src/sdp_map.svh
// Constants of the SDRAM command and pin interface
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH
`define SDP_DATA_W       64
`define SDP_ADDR_W       13
`define SDP_BANK_W       2
`define SDP_CS_W         4
`define SDP_MASK_W       8
`define SDP_LANE_W       8
`define SDP_COL_W        10
`define SDP_ROW_W        13
`define SDP_HADDR_W      25
`define SDP_PRE_ALL_BIT  10
`define SDP_MB_LSB       23
`define SDP_IB_LSB       21
`define SDP_ROW_LSB      9
`define SDP_SUSPEND_CYC  4
`endif

// File: src/sdp_pkg.sv
// Types of the SDRAM command and pin interface
package sdp_pkg;
  // {row strobe, column strobe, write strobe}, all active low
  typedef logic [2:0] sdp_cmd_t;
  localparam sdp_cmd_t CMD_NOP  = 3'h7;
  localparam sdp_cmd_t CMD_ACT  = 3'h3;
  localparam sdp_cmd_t CMD_RD   = 3'h5;
  localparam sdp_cmd_t CMD_WR   = 3'h4;
  localparam sdp_cmd_t CMD_PRE  = 3'h2;
  localparam sdp_cmd_t CMD_REF  = 3'h1;
  localparam sdp_cmd_t CMD_MRS  = 3'h0;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ACT    = 5'h02,
    ST_XFER   = 5'h04,
    ST_PRE    = 5'h08,
    ST_SUSP   = 5'h10
  } sdp_state_e;

  typedef struct packed {
    logic        rowStrobeN;
    logic        colStrobeN;
    logic        writeStrobeN;
    logic        clkGate;
  } sdp_strobes_s;

  typedef struct packed {
    logic [1:0]  moduleBank;
    logic [1:0]  intBank;
    logic [12:0] row;
    logic [9:0]  col;
  } sdp_addr_s;
endpackage

// File: src/sdp_sdram_pins.sv
// SDRAM command, address, strobe and data pin interface
`include "sdp_map.svh"
`timescale 1ns/10ps
`default_nettype none

module sdp_sdram_pins #(
  parameter int DATA_W = `SDP_DATA_W,
  parameter int MASK_W = `SDP_MASK_W
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,
  input  wire logic                     clkEn,
  // Request side
  input  wire logic                     reqValid,
  output logic                          reqReady,
  input  wire logic                     reqWrite,
  input  wire logic [`SDP_HADDR_W-1:0]  reqAddr,
  input  wire logic [DATA_W-1:0]        reqWrData,
  input  wire logic [MASK_W-1:0]        reqByteEn,
  output logic                          rdValid,
  output logic [DATA_W-1:0]             rdData,
  // Power state
  input  wire logic                     suspendReq,
  output logic                          inSuspend,
  // Memory pins
  input  wire logic [DATA_W-1:0]        memory_data_bus_i,
  output logic [DATA_W-1:0]             memory_data_bus_o,
  output logic                          memory_data_bus_oe,
  output logic [`SDP_ADDR_W-1:0]        row_col_address,
  output logic [`SDP_BANK_W-1:0]        intBankSel,
  output logic [`SDP_CS_W-1:0]          moduleSelN,
  output logic                          row_strobe_pair_a_n,
  output logic                          row_strobe_pair_b_n,
  output logic                          col_strobe_pair_a_n,
  output logic                          col_strobe_pair_b_n,
  output logic                          write_strobe_pair_a_n,
  output logic                          write_strobe_pair_b_n,
  output logic                          clk_gate_pair_a,
  output logic                          clk_gate_pair_b,
  output logic [MASK_W-1:0]             byteMask
);

  // ----------------------------------------------------------------
  // Address split and command helpers
  // ----------------------------------------------------------------
  // 8-byte words times 2^25 = 256 MB: 4 modules, 4 banks, 4096 rows, 512 columns
  // Top row and column bits stay zero, so larger parts are only partly used
  function automatic sdp_pkg::sdp_addr_s splitAddr(input logic [`SDP_HADDR_W-1:0] a);
    sdp_pkg::sdp_addr_s s;
    s.moduleBank = a[`SDP_MB_LSB +: 2];
    s.intBank    = a[`SDP_IB_LSB +: 2];
    s.row        = {1'h0, a[`SDP_ROW_LSB +: 12]};
    s.col        = {1'h0, a[`SDP_ROW_LSB-1:0]};
    return s;
  endfunction

  // Active-low select of one module bank
  function automatic logic [`SDP_CS_W-1:0] selOne(input logic [1:0] mb);
    logic [`SDP_CS_W-1:0] v;
    v = '1;
    v[mb] = 1'b0;
    return v;
  endfunction

  sdp_pkg::sdp_state_e   state_q;
  sdp_pkg::sdp_addr_s    addr_q;
  logic                  write_q;
  logic [DATA_W-1:0]     wrData_q;
  logic [MASK_W-1:0]     byteEn_q;
  sdp_pkg::sdp_cmd_t     cmd_q;
  logic [`SDP_CS_W-1:0]  sel_q;
  logic                  cke_q;
  logic                  rdPend_q;
  logic                  rdLat_q;
  logic [2:0]            suspCnt_q;

  sdp_pkg::sdp_addr_s    reqSplit;
  assign reqSplit = splitAddr(reqAddr);
  assign reqReady = (state_q == sdp_pkg::ST_IDLE) && !suspendReq;
  assign inSuspend = (state_q == sdp_pkg::ST_SUSP);

  // ----------------------------------------------------------------
  // Sequencer: one access is activate, transfer, precharge
  // ----------------------------------------------------------------
  // No bank is ever left open when idle, so suspend is always safe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= sdp_pkg::ST_IDLE;
    end else if (clkEn) begin
      unique case (state_q)
        sdp_pkg::ST_IDLE: begin
          if (suspendReq) begin
            state_q <= sdp_pkg::ST_SUSP;
          end else if (reqValid) begin
            state_q <= sdp_pkg::ST_ACT;
          end
        end
        sdp_pkg::ST_ACT:  state_q <= sdp_pkg::ST_XFER;
        sdp_pkg::ST_XFER: state_q <= sdp_pkg::ST_PRE;
        sdp_pkg::ST_PRE:  state_q <= sdp_pkg::ST_IDLE;
        sdp_pkg::ST_SUSP: begin
          if (!suspendReq) begin
            state_q <= sdp_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // Request capture
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      addr_q   <= '0;
      write_q  <= 1'b0;
      wrData_q <= '0;
      byteEn_q <= '0;
    end else if (clkEn && reqReady && reqValid) begin
      addr_q   <= reqSplit;
      write_q  <= reqWrite;
      wrData_q <= reqWrData;
      byteEn_q <= reqByteEn;
    end
  end

  // ----------------------------------------------------------------
  // Command, address and select pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cmd_q           <= sdp_pkg::CMD_NOP;
      sel_q           <= '1;
      row_col_address <= '0;
      intBankSel      <= '0;
    end else if (clkEn) begin
      cmd_q <= sdp_pkg::CMD_NOP;
      sel_q <= '1;
      unique case (state_q)
        sdp_pkg::ST_IDLE: begin
          if (reqValid && !suspendReq) begin
            cmd_q           <= sdp_pkg::CMD_ACT;
            sel_q           <= selOne(reqSplit.moduleBank);
            row_col_address <= reqSplit.row;
            intBankSel      <= reqSplit.intBank;
          end
        end
        sdp_pkg::ST_ACT: begin
          cmd_q           <= write_q ? sdp_pkg::CMD_WR : sdp_pkg::CMD_RD;
          sel_q           <= selOne(addr_q.moduleBank);
          row_col_address <= {3'h0, addr_q.col};
          intBankSel      <= addr_q.intBank;
        end
        sdp_pkg::ST_XFER: begin
          cmd_q <= sdp_pkg::CMD_PRE;
          sel_q <= selOne(addr_q.moduleBank);
          row_col_address[`SDP_PRE_ALL_BIT] <= 1'b0;
        end
        default: begin
        end
      endcase
    end
  end

  // Clock enable drops only once in suspend, banks already closed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cke_q <= 1'b1;
    end else if (clkEn) begin
      cke_q <= !(state_q == sdp_pkg::ST_SUSP && suspendReq);
    end
  end

  // Deselected pair sees NOP strobes so it cannot misread a command
  always_comb begin
    moduleSelN            = sel_q;
    row_strobe_pair_a_n   = (&sel_q[1:0]) ? 1'b1 : cmd_q[2];
    col_strobe_pair_a_n   = (&sel_q[1:0]) ? 1'b1 : cmd_q[1];
    write_strobe_pair_a_n = (&sel_q[1:0]) ? 1'b1 : cmd_q[0];
    row_strobe_pair_b_n   = (&sel_q[3:2]) ? 1'b1 : cmd_q[2];
    col_strobe_pair_b_n   = (&sel_q[3:2]) ? 1'b1 : cmd_q[1];
    write_strobe_pair_b_n = (&sel_q[3:2]) ? 1'b1 : cmd_q[0];
    clk_gate_pair_a       = cke_q;
    clk_gate_pair_b       = cke_q;
  end

  // ----------------------------------------------------------------
  // Data bus and byte masks
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      memory_data_bus_o  <= '0;
      memory_data_bus_oe <= 1'b0;
      byteMask           <= '0;
    end else if (clkEn) begin
      memory_data_bus_oe <= 1'b0;
      byteMask           <= '0;
      if (state_q == sdp_pkg::ST_ACT) begin
        memory_data_bus_oe <= write_q;
        memory_data_bus_o  <= wrData_q;
        byteMask           <= write_q ? ~byteEn_q : '1;
      end
    end
  end

  // Read data sampled one cycle after the read command, latency 1
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdPend_q <= 1'b0;
      rdLat_q  <= 1'b0;
      rdValid  <= 1'b0;
      rdData   <= '0;
    end else if (clkEn) begin
      // Pending marks the read command cycle, latency marks the data cycle
      rdPend_q <= (state_q == sdp_pkg::ST_ACT) && !write_q;
      rdLat_q  <= rdPend_q;
      rdValid  <= rdLat_q;
      if (rdLat_q) begin
        rdData <= memory_data_bus_i;
      end
    end
  end

endmodule
`default_nettype wire

// File: sim/sdp_checker.sv
// Pin protocol checker for the SDRAM pin interface
`timescale 1ns/10ps
`default_nettype none
module sdp_checker (
  // Request and power side
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       reqValid,
  input wire logic       reqReady,
  input wire logic       reqWrite,
  input wire logic [24:0] reqAddr,
  input wire logic       rdValid,
  input wire logic       suspendReq,
  input wire logic       inSuspend,
  // Memory pins
  input wire logic       memory_data_bus_oe,
  input wire logic [3:0] moduleSelN,
  input wire logic [7:0] byteMask,
  input wire logic       row_strobe_pair_a_n,
  input wire logic       row_strobe_pair_b_n,
  input wire logic       col_strobe_pair_a_n,
  input wire logic       col_strobe_pair_b_n,
  input wire logic       write_strobe_pair_a_n,
  input wire logic       write_strobe_pair_b_n,
  input wire logic       clk_gate_pair_a,
  input wire logic       clk_gate_pair_b
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire tk = reqValid && reqReady;
  property p_act; tk |=> moduleSelN == ~(4'h1 << $past(reqAddr[24:23])) &&
    !(row_strobe_pair_a_n && row_strobe_pair_b_n) && col_strobe_pair_a_n && col_strobe_pair_b_n; endproperty
  a_act: assert property (p_act) else $error("bad activate");
  property p_rd; tk && !reqWrite |=> ##1 byteMask == 8'hff && !(col_strobe_pair_a_n && col_strobe_pair_b_n) &&
    write_strobe_pair_a_n && write_strobe_pair_b_n && !memory_data_bus_oe; endproperty
  a_rd: assert property (p_rd) else $error("bad read");
  property p_wr; tk && reqWrite |=> ##1 memory_data_bus_oe && !(write_strobe_pair_a_n && write_strobe_pair_b_n); endproperty
  a_wr: assert property (p_wr) else $error("bad write");
  property p_rdv; tk && !reqWrite |-> ##4 rdValid; endproperty
  a_rdv: assert property (p_rdv) else $error("late data");
  property p_pb; moduleSelN[3:2] == 2'b11 |-> row_strobe_pair_b_n; endproperty
  a_pb: assert property (p_pb) else $error("pair b");
  property p_pa; moduleSelN[1:0] == 2'h3 |-> row_strobe_pair_a_n && col_strobe_pair_a_n && write_strobe_pair_a_n; endproperty
  a_pa: assert property (p_pa) else $error("pair a");
  property p_ckab; clk_gate_pair_a == clk_gate_pair_b; endproperty
  a_ckab: assert property (p_ckab) else $error("gates differ");
  property p_susp; $rose(inSuspend) |=> !clk_gate_pair_a && moduleSelN == 4'hf; endproperty
  a_susp: assert property (p_susp) else $error("gate on");
  property p_norm; !suspendReq [*3] |-> clk_gate_pair_a; endproperty
  a_norm: assert property (p_norm) else $error("gate off");
endmodule
bind sdp_sdram_pins sdp_checker chk_u (.*);
`default_nettype wire

// File: sim/sdp_mem_model.sv
// Behavioural SDRAM, four module banks on the selected strobe pair
`timescale 1ns/10ps
`default_nettype none
module sdp_mem_model (
  // Controller pins
  input  wire logic        clk,
  input  wire logic [3:0]  selN,
  input  wire logic [2:0]  cmd,
  input  wire logic        cke,
  input  wire logic [1:0]  ba,
  input  wire logic [12:0] addr,
  input  wire logic [63:0] dqIn,
  input  wire logic [7:0]  dm,
  // Read data
  output logic      [63:0] dqOut
);
  logic [63:0] mem [logic [26:0]];
  logic [12:0] row_q;
  wire         on = cke && !(&selN);
  wire   [1:0] mb = !selN[0] ? 2'h0 : !selN[1] ? 2'h1 : !selN[2] ? 2'h2 : 2'h3;
  initial dqOut = 64'h0;
  // Released bus shows a toggling pattern, never a held value
  always @(posedge clk) begin
    dqOut <= ~dqOut;
    if (on && cmd == sdp_pkg::CMD_ACT) row_q <= addr;
    if (on && cmd == sdp_pkg::CMD_RD) dqOut <= mem[{mb, ba, row_q, addr[9:0]}];
    if (on && cmd == sdp_pkg::CMD_WR)
      for (int i = 0; i < 8; i++) if (!dm[i]) mem[{mb, ba, row_q, addr[9:0]}][8*i+:8] = dqIn[8*i+:8];
  end
endmodule
`default_nettype wire

// File: sim/sdp_sdram_pins_test.sv
// Self-checking bench for the SDRAM pin interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s %h %h", nm, e, g); end end
module sdp_sdram_pins_test;
  logic        clk, rst_b, clkEn, reqValid, reqReady, reqWrite, rdValid, suspendReq, inSuspend;
  logic        memory_data_bus_oe, clk_gate_pair_a, clk_gate_pair_b;
  logic        row_strobe_pair_a_n, row_strobe_pair_b_n, col_strobe_pair_a_n, col_strobe_pair_b_n;
  logic        write_strobe_pair_a_n, write_strobe_pair_b_n;
  logic [7:0]  reqByteEn, byteMask;
  logic [1:0]  intBankSel;
  logic [3:0]  moduleSelN;
  logic [12:0] row_col_address;
  logic [24:0] reqAddr;
  logic [63:0] reqWrData, rdData, memory_data_bus_i, memory_data_bus_o;
  logic [63:0] expMem [logic [24:0]];
  logic [24:0] adr [8];
  int          fail_count = 0, n_tests = 0, seed = 85265;
  sdp_sdram_pins dut_u (.*);
  sdp_mem_model mem_u (.clk(clk), .selN(moduleSelN), .ba(intBankSel),
    .cke(moduleSelN[1:0] != 2'h3 ? clk_gate_pair_a : clk_gate_pair_b),
    .cmd(moduleSelN[1:0] != 2'h3 ? {row_strobe_pair_a_n, col_strobe_pair_a_n, write_strobe_pair_a_n}
                                 : {row_strobe_pair_b_n, col_strobe_pair_b_n, write_strobe_pair_b_n}),
    .addr(row_col_address),
    .dqIn(memory_data_bus_o), .dm(byteMask), .dqOut(memory_data_bus_i));
  // ----------------------------------------
  // Expected memory and bus cycles
  // ----------------------------------------
  function automatic logic [63:0] merge(input logic [63:0] o, n, input logic [7:0] be);
    for (int i = 0; i < 8; i++) if (be[i]) o[8*i+:8] = n[8*i+:8];
    return o;
  endfunction
  task automatic acc(input logic w, input logic [24:0] a, input logic [63:0] d, input logic [7:0] be);
    int k;
    @(posedge clk);
    #1;
    {reqValid, reqWrite, reqAddr, reqWrData, reqByteEn} = {1'b1, w, a, d, be};
    k = 0;
    while (reqReady !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    if (k == 20) fail_count++;
    `CHK("row", {1'h0, a[20:9]}, row_col_address)
    `CHK("bank", a[22:21], intBankSel)
    `CHK("sel", ~(4'h1 << a[24:23]), moduleSelN)
    `CHK("acta", a[24] ? 3'h7 : 3'h3, {row_strobe_pair_a_n, col_strobe_pair_a_n, write_strobe_pair_a_n})
    `CHK("actb", a[24] ? 3'h3 : 3'h7, {row_strobe_pair_b_n, col_strobe_pair_b_n, write_strobe_pair_b_n})
    @(posedge clk);
    #1;
    `CHK("col", {1'h0, a[8:0]}, row_col_address[9:0])
    `CHK("cmd", w ? 3'h4 : 3'h5, a[24] ? {row_strobe_pair_b_n, col_strobe_pair_b_n, write_strobe_pair_b_n}
                                      : {row_strobe_pair_a_n, col_strobe_pair_a_n, write_strobe_pair_a_n})
    `CHK("oe", w, memory_data_bus_oe)
    `CHK("mask", w ? ~be : 8'hff, byteMask)
    if (w) begin
      `CHK("wdata", d, memory_data_bus_o)
      expMem[a] = merge(expMem[a], d, be);
    end else begin
      for (k = 0; rdValid !== 1'b1 && k < 8; k++) @(posedge clk) #1;
      `CHK("rdvalid", 1'b1, rdValid)
      `CHK("rdata", expMem[a], rdData)
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    close_out;
  end
  initial begin
    {rst_b, clkEn, reqValid, reqWrite, suspendReq, reqAddr, reqWrData, reqByteEn} = {5'b01000, 97'h0};
    repeat (5) @(posedge clk);
    #1;
    `CHK("rstsel", 4'hf, moduleSelN)
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      adr[i] = i == 0 ? 25'h0 : i == 1 ? 25'h1ffffff : 25'($random(seed));
      acc(1'b1, adr[i], {$random(seed), $random(seed)}, 8'hff);
      acc(1'b1, adr[i], {$random(seed), $random(seed)}, i == 2 ? 8'h00 : 8'($random(seed)));
    end
    for (int i = 0; i < 8; i++) acc(1'b0, adr[i], 64'h0, 8'h0);
    // Frozen clock enable must keep the sequencer out of suspend
    {clkEn, suspendReq} = 2'b01;
    repeat (3) @(posedge clk);
    #1;
    `CHK("freeze", 1'b0, inSuspend)
    {clkEn, suspendReq} = 2'b10;
    @(posedge clk);
    #1;
    // Request held during suspend must be refused
    {suspendReq, reqValid, reqWrite} = 3'b110;
    repeat (4) @(posedge clk);
    #1;
    `CHK("cke", 2'b00, {clk_gate_pair_a, clk_gate_pair_b})
    `CHK("insusp", 1'b1, inSuspend)
    `CHK("refuse", 4'hf, moduleSelN)
    {suspendReq, reqValid} = 2'b00;
    repeat (3) @(posedge clk);
    #1;
    `CHK("wake", 1'b1, clk_gate_pair_a)
    acc(1'b0, adr[1], 64'h0, 8'h0);
    close_out;
  end
endmodule
`default_nettype wire
